// ### tbrw_pkg.sv
// Purpose: shared constants and carriers for the table read and otp write block
// Assumes: 8-bit data registers, 16-bit program words, 11-bit word address
// Notes: register offsets are byte addresses on the plain register port
package tbrw_pkg;
   // register offsets
   localparam logic [7:0] TBRW_OFS_PTR_LOW = 8'h00; // low table pointer
   localparam logic [7:0] TBRW_OFS_PTR_HIGH = 8'h01; // high table pointer
   localparam logic [7:0] TBRW_OFS_HIGH_LATCH = 8'h02; // table high byte latch, read only
   localparam logic [7:0] TBRW_OFS_WCTRL = 8'h03; // otp_write_control
   localparam logic [7:0] TBRW_OFS_WDATA_LOW = 8'h04; // write_data_low
   localparam logic [7:0] TBRW_OFS_WDATA_HIGH = 8'h05; // write_data_high
   localparam logic [7:0] TBRW_OFS_STATUS = 8'h06; // busy and fault status
   // control field positions
   localparam int TBRW_BIT_ARM = 3; // write_arm
   localparam int TBRW_BIT_GO = 2; // write go
   // reset values
   localparam logic [7:0] TBRW_RST_BYTE = 8'h00;
   // memory layout
   localparam int TBRW_ADDR_W = 11; // 2k words
   localparam int TBRW_WORD_W = 16;
   localparam logic [10:0] TBRW_LAST_PAGE = 11'h700; // last page base
   // timing: table instructions take two instruction cycles
   localparam int TBRW_INSTR_CYCLES = 2;
   // default write cycle length in system clocks
   localparam int TBRW_WRITE_CLKS = 64;
   // table read request from the core
   typedef struct packed
   {
      logic valid; // one-cycle request
      logic full_ptr; // 1: use both pointers, 0: last page
      logic [7:0] dest; // destination data register
   } tbrw_read_req_s;
   // table read result back to the core
   typedef struct packed
   {
      logic valid; // one-cycle pulse
      logic [7:0] dest; // destination data register
      logic [7:0] data; // low byte of word
   } tbrw_read_rsp_s;
   // engine states
   typedef enum logic [1:0]
   {
      TBRW_IDLE = 2'b00,
      TBRW_READ = 2'b01,
      TBRW_WRITE = 2'b10
   } tbrw_state_e;
endpackage

// ### tbrw_otp_array.sv
// Purpose: one-time-programmable word store with a write-once mark per word
// Assumes: read data is registered, one cycle after the address
// Notes: a word already written refuses any further write
module tbrw_otp_array
   import tbrw_pkg::*;
#(
   parameter int ADDR_W = TBRW_ADDR_W,
   parameter int WORD_W = TBRW_WORD_W,
   parameter int HIGH_USED = 8 // implemented bits of the high byte
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic [WORD_W-1:0] rd_data_o,
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire logic [WORD_W-1:0] wr_data_i,
   output logic wr_refused_o
);
   localparam int DEPTH = 1 << ADDR_W;
   logic [WORD_W-1:0] mem [DEPTH]; // word storage
   logic [DEPTH-1:0] used = '0; // write-once marks, blank at power-up
   logic [WORD_W-1:0] high_mask; // clears unimplemented high bits
   // low byte plus the implemented high bits; cut to the word width on purpose
   assign high_mask = WORD_W'((64'h1 << (HIGH_USED + 8)) - 64'h1);
   // registered read, unimplemented upper bits forced to zero
   always_ff @(posedge clk_sys_i)
   begin
      rd_data_o <= mem[rd_addr_i] & high_mask;
   end
   // program a blank word once; no erase exists
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         wr_refused_o <= 1'b0;
      end
      else
      begin
         wr_refused_o <= wr_en_i & used[wr_addr_i];
      end
      if (wr_en_i && !used[wr_addr_i])
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end
   // marks survive reset: they model fuses, not state
   always_ff @(posedge clk_sys_i)
   begin
      if (wr_en_i)
      begin
         used[wr_addr_i] <= 1'b1;
      end
   end
endmodule // tbrw_otp_array

// ### tbrw_core.sv
// Purpose: table read and one-shot otp write engine with register port
// Assumes: core issues one table read at a time and honours stall_o
// Notes: an instruction cycle is one clock here
//
// The plain strobed port and the register offsets were left to the implementer.
module tbrw_core
   import tbrw_pkg::*;
#(
   parameter int WRITE_CLKS = TBRW_WRITE_CLKS,
   parameter int HIGH_USED = 8
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire tbrw_read_req_s read_req_i,
   output tbrw_read_rsp_s read_rsp_o,
   output logic stall_o,
   input wire logic vpp_mode_i,
   input wire logic port_oe_req_i,
   output logic port_oe_o
);
   logic [7:0] ptr_low; // low table pointer
   logic [7:0] ptr_high; // high table pointer
   logic [7:0] high_latch; // table_high_byte_latch
   logic [7:0] wdata_low; // write_data_low
   logic [7:0] wdata_high; // write_data_high
   logic write_arm; // arm bit
   logic write_go; // go bit
   logic arm_prev; // arm was set by the previous cycle's write
   logic fault; // sticky: last write hit a used word
   tbrw_state_e state;
   logic [15:0] wcount; // write cycle counter
   logic [7:0] pend_dest; // held destination of a read
   logic [TBRW_ADDR_W-1:0] rd_addr;
   logic [TBRW_ADDR_W-1:0] next_rd_addr;
   logic [TBRW_WORD_W-1:0] word;
   logic arr_wr;
   logic refused;
   logic vpp_s1, vpp_s2, oe_s1, oe_s2; // pin synchronisers
   logic go_write; // write accepted this cycle
   // address of a table read: both pointers, or last page plus low pointer
   always_comb
   begin
      if (read_req_i.full_ptr)
      begin
         next_rd_addr = {ptr_high[2:0], ptr_low};
      end
      else
      begin
         next_rd_addr = TBRW_LAST_PAGE | {3'b000, ptr_low};
      end
   end
   // array address: writes use last page plus low pointer only
   assign rd_addr = next_rd_addr;
   assign arr_wr = (state == TBRW_WRITE) && (wcount == 16'(WRITE_CLKS - 1));
   tbrw_otp_array #(
      .HIGH_USED(HIGH_USED)
   ) u_array (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .rd_addr_i(rd_addr),
      .rd_data_o(word),
      .wr_en_i(arr_wr),
      .wr_addr_i(TBRW_LAST_PAGE | {3'b000, ptr_low}),
      .wr_data_i({wdata_high, wdata_low}),
      .wr_refused_o(refused)
   );
   // accept go only when arm was written the cycle before
   assign go_write = wr_i && (addr_i == TBRW_OFS_WCTRL) && wdata_i[TBRW_BIT_GO]
      && arm_prev && write_arm && (state == TBRW_IDLE);
   // engine sequencing
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state <= TBRW_IDLE;
         wcount <= 16'h0000;
         pend_dest <= 8'h00;
      end
      else
      begin
         case (state)
            TBRW_IDLE:
            begin
               if (go_write)
               begin
                  state <= TBRW_WRITE;
                  wcount <= 16'h0000;
               end
               else if (read_req_i.valid)
               begin
                  state <= TBRW_READ;
                  pend_dest <= read_req_i.dest;
               end
            end
            TBRW_READ:
            begin
               state <= TBRW_IDLE; // second cycle finishes the read
            end
            TBRW_WRITE:
            begin
               if (wcount == 16'(WRITE_CLKS - 1))
               begin
                  state <= TBRW_IDLE;
               end
               wcount <= wcount + 16'h0001;
            end
            default:
            begin
               state <= TBRW_IDLE;
            end
         endcase
      end
   end
   // read result valid and high latch only on a table read; dest and data load every cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         high_latch <= TBRW_RST_BYTE;
         read_rsp_o <= '0;
      end
      else
      begin
         read_rsp_o.valid <= (state == TBRW_READ);
         read_rsp_o.dest <= pend_dest;
         read_rsp_o.data <= word[7:0];
         if (state == TBRW_READ)
         begin
            high_latch <= word[15:8];
         end
      end
   end
   // stall the core during a write
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         stall_o <= 1'b0;
      end
      else
      begin
         stall_o <= go_write || ((state == TBRW_WRITE) && !arr_wr);
      end
   end
   // software registers
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ptr_low <= TBRW_RST_BYTE;
         ptr_high <= TBRW_RST_BYTE;
         wdata_low <= TBRW_RST_BYTE;
         wdata_high <= TBRW_RST_BYTE;
         write_arm <= 1'b0;
         write_go <= 1'b0;
         arm_prev <= 1'b0;
         fault <= 1'b0;
      end
      else
      begin
         arm_prev <= 1'b0;
         if (arr_wr)
         begin
            write_arm <= 1'b0;
            write_go <= 1'b0;
         end
         else if (wr_i && state == TBRW_IDLE)
         begin
            case (addr_i)
               TBRW_OFS_PTR_LOW: ptr_low <= wdata_i;
               TBRW_OFS_PTR_HIGH: ptr_high <= wdata_i;
               TBRW_OFS_WDATA_LOW: wdata_low <= wdata_i;
               TBRW_OFS_WDATA_HIGH: wdata_high <= wdata_i;
               TBRW_OFS_WCTRL:
               begin
                  // arm and go in one write: arm only, go ignored
                  write_arm <= wdata_i[TBRW_BIT_ARM];
                  write_go <= go_write;
                  arm_prev <= wdata_i[TBRW_BIT_ARM] && !write_arm;
               end
               default:
               begin
               end
            endcase
         end
         if (refused)
         begin
            fault <= 1'b1; // set wins, cleared by reading status
         end
         else if (rd_i && addr_i == TBRW_OFS_STATUS)
         begin
            fault <= 1'b0;
         end
      end
   end
   // read port: data stands one cycle after the strobe
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (rd_i)
      begin
         case (addr_i)
            TBRW_OFS_PTR_LOW: rdata_o <= ptr_low;
            TBRW_OFS_PTR_HIGH: rdata_o <= ptr_high;
            TBRW_OFS_HIGH_LATCH: rdata_o <= high_latch;
            TBRW_OFS_WCTRL: rdata_o <= {4'h0, write_arm, write_go, 2'b00};
            TBRW_OFS_WDATA_LOW: rdata_o <= wdata_low;
            TBRW_OFS_WDATA_HIGH: rdata_o <= wdata_high;
            TBRW_OFS_STATUS: rdata_o <= {6'h00, refused | fault, stall_o};
            default: rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end
   // pin inputs pass two flops before use
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         vpp_s1 <= 1'b0;
         vpp_s2 <= 1'b0;
         oe_s1 <= 1'b0;
         oe_s2 <= 1'b0;
      end
      else
      begin
         vpp_s1 <= vpp_mode_i;
         vpp_s2 <= vpp_s1;
         oe_s1 <= port_oe_req_i;
         oe_s2 <= oe_s1;
      end
   end
   // shared port cannot drive while it carries programming supply
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         port_oe_o <= 1'b0;
      end
      else
      begin
         port_oe_o <= oe_s2 && !vpp_s2;
      end
   end
   // checks
   sequence arm_then_go_s;
      wr_i && addr_i == TBRW_OFS_WCTRL && wdata_i[TBRW_BIT_ARM] && !write_arm
         ##1 go_write;
   endsequence
   read_two_cycles_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == TBRW_IDLE && read_req_i.valid && !go_write) |-> ##2 read_rsp_o.valid)
      else $error("table read result not two cycles later");
   high_latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state != TBRW_READ) |=> $stable(high_latch))
      else $error("high latch changed without a table read");
   high_latch_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == TBRW_READ) |=> high_latch == $past(word[15:8]))
      else $error("high latch not loaded from word");
   low_byte_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      read_rsp_o.valid |-> read_rsp_o.data == $past(word[7:0]))
      else $error("low byte not returned");
   go_needs_arm_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == TBRW_IDLE ##1 state == TBRW_WRITE) |-> $past(arm_prev, 1))
      else $error("write started without arm");
   write_stall_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      arm_then_go_s |=> stall_o)
      else $error("core not stalled after write start");
   write_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      arr_wr |=> !write_arm && !write_go && !stall_o)
      else $error("arm and go not cleared at write end");
   last_page_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (read_req_i.valid && !read_req_i.full_ptr) |-> rd_addr[10:8] == 3'h7)
      else $error("last page read outside last page");
   vpp_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      vpp_s2 |=> !port_oe_o)
      else $error("shared port driven during programming supply");
   data_reset_a: assert property (@(posedge clk_sys_i)
      rst_i |=> wdata_low == 8'h00 && wdata_high == 8'h00)
      else $error("write data not zero after reset");
endmodule // tbrw_core

// ### tbrw_core_model.sv
// Purpose: processor core model issuing register and table read instructions
// Assumes: one instruction per clock; strobes change just after a rising edge
// Notes: the bench calls the tasks through the instance; released lines are scrambled
module tbrw_core_model
   import tbrw_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic stall_i,
   input wire logic [7:0] rdata_i,
   input wire tbrw_read_rsp_s rsp_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   output tbrw_read_req_s req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      req_o = '0;
   end
   // hold off while the write engine stalls the core
   task automatic wait_run();
      while (stall_i !== 1'b0) @(posedge clk_sys_i);
   endtask
   // end a one-cycle request; released lines get the inverse so stale data never matches
   task automatic release_bus();
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      req_o.valid <= 1'b0;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
   endtask
   // one register write cycle (pointers and data registers are loaded this way)
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      wait_run();
      @(posedge clk_sys_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      release_bus();
   endtask
   // one register read cycle; data taken in the following cycle
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      wait_run();
      @(posedge clk_sys_i);
      rd_o <= 1'b1;
      addr_o <= a;
      release_bus();
      #1 d = rdata_i;
   endtask
   // arm then go in two back-to-back instruction cycles
   task automatic arm_go();
      wait_run();
      @(posedge clk_sys_i);
      wr_o <= 1'b1;
      addr_o <= TBRW_OFS_WCTRL;
      wdata_o <= 8'(1 << TBRW_BIT_ARM);
      @(posedge clk_sys_i);
      wdata_o <= 8'(1 << TBRW_BIT_GO);
      release_bus();
   endtask
   // table read; response sampled one and two cycles after the request edge
   task automatic tab_rd(input logic full, input logic [7:0] dst,
                         output tbrw_read_rsp_s r1, output tbrw_read_rsp_s r2);
      wait_run();
      @(posedge clk_sys_i);
      req_o <= '{valid: 1'b1, full_ptr: full, dest: dst};
      release_bus();
      #1 r1 = rsp_i;
      @(posedge clk_sys_i);
      #1 r2 = rsp_i;
   endtask
endmodule // tbrw_core_model

// ### tb_top.sv
// Purpose: self-checking bench for the table read and otp write engine
// Assumes: short write cycle and six implemented high bits for quick runs
// Notes: array words are not reset, so only words written here are read back
module tb_top;
   import tbrw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WC = 4; // shortened write cycle
   localparam int HU = 6; // implemented high bits
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic vpp_mode = 1'b0;
   logic oe_req = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, stall, port_oe;
   tbrw_read_req_s req;
   tbrw_read_rsp_s rsp, r1, r2;
   logic [7:0] v;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   // rows: offset, value written, value read back (reset value read first)
   logic [7:0] row_ofs[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
   logic [7:0] row_wr[6] = '{8'h06, 8'h05, 8'h55, 8'h00, 8'ha5, 8'hff};
   logic [7:0] row_exp[6] = '{8'h06, 8'h05, 8'h00, 8'h00, 8'ha5, 8'hff};
   // 250 MHz system clock
   always #2 clk_sys_i = ~clk_sys_i;
   tbrw_core #(.WRITE_CLKS(WC), .HIGH_USED(HU)) dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .read_req_i(req), .read_rsp_o(rsp),
      .stall_o(stall), .vpp_mode_i(vpp_mode), .port_oe_req_i(oe_req), .port_oe_o(port_oe));
   tbrw_core_model core (
      .clk_sys_i(clk_sys_i), .stall_i(stall), .rdata_i(rdata), .rsp_i(rsp),
      .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .req_o(req));
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // wait for the write stall to end, bounded, and return its length
   task automatic wait_stall(output int cnt);
      cnt = 0;
      while (stall !== 1'b0 && cnt < 100)
      begin
         @(posedge clk_sys_i);
         #1 cnt++;
      end
   endtask
   // closing verdict
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         report_and_stop();
      end
   end
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      // register rows: reset value, then write and read back
      for (int i = 0; i < 6; i++)
      begin
         core.reg_rd(row_ofs[i], v);
         chk(v, 8'h00, "reset value");
         core.reg_wr(row_ofs[i], row_wr[i]);
         core.reg_rd(row_ofs[i], v);
         chk(v, row_exp[i], "readback");
      end
      $display("test registers done");
      // write 0xffa5 (high bits beyond six dropped) to word 0x706
      core.arm_go();
      #1 chk(8'(stall), 8'h01, "stall after go");
      wait_stall(n);
      chk(8'(n >= WC && n <= WC + 1), 8'h01, "write cycle length");
      core.reg_rd(TBRW_OFS_WCTRL, v);
      chk(v, 8'h00, "arm and go cleared");
      $display("test write done");
      // last-page read ignores the high pointer (holds 05)
      core.tab_rd(1'b0, 8'h3b, r1, r2);
      chk(8'(r1.valid), 8'h00, "no early response");
      chk(8'(r2.valid), 8'h01, "response at two cycles");
      chk(r2.dest, 8'h3b, "dest");
      chk(r2.data, 8'ha5, "low byte");
      core.reg_rd(TBRW_OFS_HIGH_LATCH, v);
      chk(v, 8'h3f, "high latch");
      // full-pointer read of 0x706 with high pointer 07
      core.reg_wr(TBRW_OFS_PTR_HIGH, 8'h07);
      core.tab_rd(1'b1, 8'h81, r1, r2);
      chk(r2.data, 8'ha5, "full pointer read");
      core.reg_wr(TBRW_OFS_HIGH_LATCH, 8'h00);
      core.reg_rd(TBRW_OFS_HIGH_LATCH, v);
      chk(v, 8'h3f, "latch unchanged by write");
      $display("test table read done");
      // go alone, and arm with go in one write, start nothing
      core.reg_wr(TBRW_OFS_WCTRL, 8'h04);
      #1 chk(8'(stall), 8'h00, "go without arm");
      core.reg_rd(TBRW_OFS_WCTRL, v);
      chk(v, 8'h00, "go not set");
      core.reg_wr(TBRW_OFS_WCTRL, 8'h0c);
      #1 chk(8'(stall), 8'h00, "arm and go together");
      core.reg_rd(TBRW_OFS_WCTRL, v);
      chk(v, 8'h08, "only arm set");
      core.reg_wr(TBRW_OFS_WCTRL, 8'h00);
      $display("test refused go done");
      // second write to the used word is refused
      core.reg_wr(TBRW_OFS_WDATA_LOW, 8'h5a);
      core.arm_go();
      #1 wait_stall(n);
      core.reg_rd(TBRW_OFS_STATUS, v);
      chk(v & 8'h02, 8'h02, "refused flag");
      core.tab_rd(1'b0, 8'h10, r1, r2);
      chk(r2.data, 8'ha5, "word unchanged");
      $display("test write once done");
      // mid-run reset clears the data registers but keeps the written word
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      core.reg_rd(TBRW_OFS_WDATA_LOW, v);
      chk(v, 8'h00, "low data after reset");
      core.reg_rd(TBRW_OFS_WDATA_HIGH, v);
      chk(v, 8'h00, "high data after reset");
      core.reg_wr(TBRW_OFS_PTR_LOW, 8'h06);
      core.tab_rd(1'b0, 8'h11, r1, r2);
      chk(r2.data, 8'ha5, "word kept over reset");
      $display("test mid reset done");
      // programming supply blocks the shared output
      @(posedge clk_sys_i);
      vpp_mode <= 1'b1;
      oe_req <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      #1 chk(8'(port_oe), 8'h00, "output blocked");
      @(posedge clk_sys_i);
      vpp_mode <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1 chk(8'(port_oe), 8'h01, "output allowed");
      $display("test supply pin done");
      report_and_stop();
   end
endmodule // tb_top
